// ---- hdl/dsr_consts.svh ----
// constants for the disk sector read engine: opcodes, field positions, status bits
// assumes inclusion by the engine only; the package does not include it
`ifndef DSR_CONSTS_SVH
`define DSR_CONSTS_SVH
`define DSR_OP_READ 5'h06
`define DSR_OP_READ_DEL 5'h0c
`define DSR_OP_SETTRK 8'h21
`define DSR_OP_SETTRK_MASK 8'hbf
`define DSR_PARAM_COUNT 4'h8
`define DSR_BIT_MULTI 7
`define DSR_BIT_SKIP 5
`define DSR_BIT_IPS 7
`define DSR_BIT_HEAD 2
`define DSR_BIT_RW 6
`define DSR_BIT_MSB 2
`define DSR_S0_INVALID 8'h80
`define DSR_S0_ABNORMAL 8'h40
`define DSR_S1_EOT 7
`define DSR_S1_CRC 5
`define DSR_S1_NODATA 2
`define DSR_S2_CTRLMARK 6
`define DSR_S2_CRC 5
`define DSR_S2_WRONGTRK 4
`define DSR_S2_BADTRK 1
`define DSR_BADTRK_VAL 8'hff
`define DSR_SHORT_SECTOR 14'h0080
`define DSR_MAX_SIZE_CODE 3'h6
`define DSR_SETTLE_DEFAULT 8'h08
`endif

// ---- hdl/dsr_engine.sv ----
// sector read command engine: parameter intake, implied seek, search, transfer, results
// assumes header/data-field decode, seek stepping and settle tick come from drive-side logic
// on the same clock; the transfer-end pin arrives asynchronously and is synchronised here.
//
// Function
// - after each sector the sector number increments and the next is searched.
// - multi-side reads side zero to last sector, then side one from sector one.
// - in dma mode reading continues sector after sector until transfer end.
// - going past last sector of track stops with end-of-track error.
// - size codes 0..6 decode to 128 shifted left by the code.
// - size code zero transfers data length bytes but reads whole 128-byte sector.
// - implied seek when mode and command flags both set seeks to parameter track.
// - after implied seek, wait head settle time before searching.
// - target matched on track, head, sector and size against header bytes.
// - header crc error on match sets status one bit 5, abnormal end.
// - sector not found sets status one bit 2, abnormal end.
// - header track ff sets status two bit 1; other track mismatch sets bit 4.
// - deleted mark with skip set: no transfer, status two bit 6, continue.
// - deleted mark with skip clear: transfer, set control mark, normal end.
// - data crc error sets bit 5 of status one and two, abnormal end.
// - a data write while stalled aborts the command into result phase.
// - interrupt at end of execution; error results name the sector in progress.
// - normal-end result id follows the multi-side and head end-of-track table.
// - set-track writes present track when direction bit is one, else returns it.
// - set-track byte-select bit picks upper byte when one, lower otherwise.
//
// The implementer's own choices: the strobe-only data port, with no register addresses.
`timescale 1ns/1ps
`include "dsr_consts.svh"
module dsr_engine (
  input wire logic ref_clk, // 125 MHz system clock
  input wire logic reset_n, // asynchronous reset, active low
  input wire logic dataWrite, // host writes data register
  input wire logic dataRead, // host reads data register
  input wire logic [7:0] dataIn, // host write byte
  output logic [7:0] dataOut, // host read byte, one cycle after read
  output logic resultReady, // result bytes waiting
  output logic irq, // execution phase ended
  input wire logic implied_seek_enable, // mode-level implied seek
  input wire logic [7:0] settleTicks, // head settle, in settle ticks
  input wire logic settleTick, // one-cycle time base pulse
  input wire logic transfer_end_input, // asynchronous transfer end pin
  output logic seekReq, // pulse: seek to seekTrack
  output logic [7:0] seekTrack, // target track of implied seek
  input wire logic seekDone, // seek complete pulse
  output logic searchReq, // level: looking for headers
  input wire logic hdrValid, // pulse: header decoded
  input wire logic [7:0] hdrTrack, // header track byte
  input wire logic [7:0] hdrHead, // header head byte
  input wire logic [7:0] hdrSector, // header sector byte
  input wire logic [7:0] hdrSize, // header size byte
  input wire logic hdrCrcErr, // header crc bad
  input wire logic notFound, // pulse: revolutions exhausted
  input wire logic dataMark, // pulse: data mark seen
  input wire logic deletedMark, // data mark is deleted
  input wire logic rdByteValid, // pulse: disk data byte
  input wire logic [7:0] rdByte, // disk data byte
  input wire logic dataCrcErr, // pulse: data field crc bad
  input wire logic dataCrcOk, // pulse: data field crc good
  output logic readFieldReq, // level: read current data field
  output logic xferValid, // pulse: byte toward host
  output logic [7:0] xferByte, // byte toward host
  output logic head_select // head in use
);
  import dsr_pkg::*;
  // ***************
  // helpers
  // ***************
  // field size from code; codes past 6 clamp to the largest
  function automatic logic [13:0] sizeBytes(input logic [7:0] code);
    logic [2:0] c;
    c = (code > {5'h00, `DSR_MAX_SIZE_CODE}) ? `DSR_MAX_SIZE_CODE : code[2:0];
    sizeBytes = `DSR_SHORT_SECTOR << c;
  endfunction
  // ***************
  // state
  // ***************
  dsr_state_t state_q, state_d;
  dsr_cmd_t cmd_q;
  logic [7:0] opc_q;
  logic [7:0] prm_q [0:7];
  logic [3:0] prmCnt_q;
  logic [7:0] trk_q, hd_q, sec_q, sz_q, eot_q, dtl_q;
  logic [7:0] st0_q, st1_q, st2_q;
  logic [15:0] ptn_q;
  logic [13:0] byteCnt_q;
  logic [7:0] settle_q;
  logic [2:0] resIdx_q, resLen_q;
  logic finalSec_q;
  logic tcMeta_q, tcSync_q, tcSeen_q;
  logic [7:0] dataOut_q;
  logic irq_q, seekReq_q, xferValid_q;
  logic [7:0] xferByte_q;
  // transfer end pin synchroniser
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tcMeta_q <= 1'b0;
      tcSync_q <= 1'b0;
    end else begin
      tcMeta_q <= transfer_end_input;
      tcSync_q <= tcMeta_q;
    end
  end
  // ***************
  // decode
  // ***************
  wire isReadOp = (dataIn[4:0] == `DSR_OP_READ) || (dataIn[4:0] == `DSR_OP_READ_DEL);
  wire isSetTrk = (dataIn & `DSR_OP_SETTRK_MASK) == `DSR_OP_SETTRK;
  wire readDelCmd = (opc_q[4:0] == `DSR_OP_READ_DEL);
  wire multiSide = opc_q[`DSR_BIT_MULTI];
  wire skipFlag = opc_q[`DSR_BIT_SKIP];
  wire cmdIps = prm_q[0][`DSR_BIT_IPS];
  wire lastPrm = dataWrite && (prmCnt_q == (`DSR_PARAM_COUNT - 4'h1));
  // header compare over all four id bytes
  wire hdrMatch = (hdrTrack == trk_q) && (hdrHead == hd_q) && (hdrSector == sec_q)
    && (hdrSize == sz_q);
  // a mark of the other kind from the one being read is a control mark
  wire ctrlMark = readDelCmd ? !deletedMark : deletedMark;
  wire [13:0] fieldLen = sizeBytes(sz_q);
  wire [13:0] xferLen = (sz_q == 8'h00) ? {6'h00, dtl_q} : fieldLen;
  wire atEot = (sec_q == eot_q);
  wire stalled = (state_q == DSR_SEEK) || (state_q == DSR_SETTLE) || (state_q == DSR_SEARCH);
  wire abortWr = stalled && dataWrite;
  wire settleDone = (settle_q == 8'h00);
  wire stopNow = tcSeen_q || tcSync_q;
  wire resLast = dataRead && (resIdx_q == resLen_q - 3'h1);
  // ***************
  // sequencer
  // ***************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      DSR_IDLE: begin
        if (dataWrite) begin
          state_d = (isReadOp || isSetTrk) ? DSR_PARAM : DSR_RESULT;
        end
      end
      DSR_PARAM: begin
        if (cmd_q == DSR_CMD_SETTRK && dataWrite && prmCnt_q == 4'h1) begin
          state_d = DSR_RESULT;
        end else if (lastPrm) begin
          state_d = (implied_seek_enable && cmdIps) ? DSR_SEEK : DSR_SEARCH;
        end
      end
      DSR_SEEK: state_d = abortWr ? DSR_RESULT : (seekDone ? DSR_SETTLE : DSR_SEEK);
      DSR_SETTLE: state_d = abortWr ? DSR_RESULT : (settleDone ? DSR_SEARCH : DSR_SETTLE);
      DSR_SEARCH: begin
        if (abortWr || notFound) begin
          state_d = DSR_RESULT;
        end else if (hdrValid && hdrMatch) begin
          state_d = hdrCrcErr ? DSR_RESULT : DSR_DATA;
        end
      end
      DSR_DATA: begin
        if (dataCrcErr) begin
          state_d = DSR_RESULT;
        end else if (dataCrcOk) begin
          state_d = DSR_NEXT;
        end
      end
      DSR_NEXT: begin
        // a normal-end control mark or transfer end or past-track stops here
        if (stopNow || finalSec_q || (atEot && !(multiSide && hd_q[0] == 1'b0))) begin
          state_d = DSR_RESULT;
        end else begin
          state_d = DSR_SEARCH;
        end
      end
      DSR_RESULT: state_d = resLast ? DSR_IDLE : DSR_RESULT;
      default: state_d = DSR_IDLE;
    endcase
  end
  // ***************
  // datapath
  // ***************
  // parameter capture, id advance and status accumulation
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= DSR_IDLE;
      cmd_q <= DSR_CMD_READ;
      opc_q <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        prm_q[i] <= 8'h00;
      end
      prmCnt_q <= 4'h0;
      trk_q <= 8'h00;
      hd_q <= 8'h00;
      sec_q <= 8'h00;
      sz_q <= 8'h00;
      eot_q <= 8'h00;
      dtl_q <= 8'h00;
      st0_q <= 8'h00;
      st1_q <= 8'h00;
      st2_q <= 8'h00;
      ptn_q <= 16'h0000;
      byteCnt_q <= 14'h0000;
      settle_q <= 8'h00;
      resIdx_q <= 3'h0;
      resLen_q <= 3'h0;
      finalSec_q <= 1'b0;
      tcSeen_q <= 1'b0;
      irq_q <= 1'b0;
      seekReq_q <= 1'b0;
    end else begin
      state_q <= state_d;
      seekReq_q <= 1'b0;
      irq_q <= 1'b0;
      if (state_q != DSR_IDLE && tcSync_q) begin
        tcSeen_q <= 1'b1;
      end
      unique case (state_q)
        DSR_IDLE: begin
          prmCnt_q <= 4'h0;
          resIdx_q <= 3'h0;
          tcSeen_q <= 1'b0;
          finalSec_q <= 1'b0;
          if (dataWrite) begin
            opc_q <= dataIn;
            st0_q <= 8'h00;
            st1_q <= 8'h00;
            st2_q <= 8'h00;
            cmd_q <= isReadOp ? DSR_CMD_READ : (isSetTrk ? DSR_CMD_SETTRK : DSR_CMD_INVALID);
            if (!isReadOp && !isSetTrk) begin
              st0_q <= `DSR_S0_INVALID;
              resLen_q <= 3'h1;
            end
          end
        end
        DSR_PARAM: begin
          if (dataWrite) begin
            prm_q[prmCnt_q[2:0]] <= dataIn;
            prmCnt_q <= prmCnt_q + 4'h1;
          end
          if (cmd_q == DSR_CMD_SETTRK && dataWrite && prmCnt_q == 4'h1) begin
            resLen_q <= 3'h1;
            if (opc_q[`DSR_BIT_RW]) begin
              if (prm_q[0][`DSR_BIT_MSB]) begin
                ptn_q[15:8] <= dataIn;
              end else begin
                ptn_q[7:0] <= dataIn;
              end
            end
          end else if (lastPrm) begin
            trk_q <= prm_q[1];
            hd_q <= prm_q[2];
            sec_q <= prm_q[3];
            sz_q <= prm_q[4];
            eot_q <= prm_q[5];
            dtl_q <= dataIn;
            resLen_q <= 3'h7;
            seekReq_q <= implied_seek_enable && cmdIps;
            settle_q <= settleTicks;
          end
        end
        DSR_SETTLE: begin
          if (settleTick && !settleDone) begin
            settle_q <= settle_q - 8'h01;
          end
        end
        DSR_SEARCH: begin
          byteCnt_q <= 14'h0000;
          if (hdrValid && hdrTrack == `DSR_BADTRK_VAL) begin
            st2_q[`DSR_S2_BADTRK] <= 1'b1;
          end else if (hdrValid && hdrTrack != trk_q) begin
            st2_q[`DSR_S2_WRONGTRK] <= 1'b1;
          end
          if (notFound) begin
            st1_q[`DSR_S1_NODATA] <= 1'b1;
          end
          if (hdrValid && hdrMatch && hdrCrcErr) begin
            st1_q[`DSR_S1_CRC] <= 1'b1;
          end
        end
        DSR_DATA: begin
          if (dataMark && ctrlMark) begin
            st2_q[`DSR_S2_CTRLMARK] <= 1'b1;
            finalSec_q <= !skipFlag;
          end
          if (rdByteValid) begin
            byteCnt_q <= byteCnt_q + 14'h0001;
          end
          if (dataCrcErr) begin
            st1_q[`DSR_S1_CRC] <= 1'b1;
            st2_q[`DSR_S2_CRC] <= 1'b1;
          end
        end
        DSR_NEXT: begin
          // advance the id whether reading on or reporting a normal end
          if (!atEot) begin
            sec_q <= sec_q + 8'h01;
          end else if (!stopNow && !finalSec_q && !(multiSide && hd_q[0] == 1'b0)) begin
            st1_q[`DSR_S1_EOT] <= 1'b1;
          end else begin
            sec_q <= 8'h01;
            if (multiSide && hd_q[0] == 1'b0) begin
              hd_q <= 8'h01;
            end else begin
              trk_q <= trk_q + 8'h01;
              if (multiSide) begin
                hd_q <= 8'h00;
              end
            end
          end
        end
        DSR_RESULT: begin
          resIdx_q <= resIdx_q + {2'h0, dataRead};
        end
        default: ;
      endcase
      // abnormal end whenever a status-one error bit has been raised; idle excluded so a
      // stale read code cannot flag an invalid opcode as a read ending
      if (state_d == DSR_RESULT && state_q != DSR_RESULT && state_q != DSR_IDLE
          && cmd_q == DSR_CMD_READ) begin
        irq_q <= 1'b1;
        if (st1_q != 8'h00 || notFound || dataCrcErr || (hdrValid && hdrMatch && hdrCrcErr)
            || (state_q == DSR_NEXT && atEot && !stopNow && !finalSec_q
            && !(multiSide && hd_q[0] == 1'b0))) begin
          st0_q <= `DSR_S0_ABNORMAL | {5'h00, hd_q[0], prm_q[0][1:0]};
        end
      end
    end
  end
  // ***************
  // host output and transfer
  // ***************
  wire [7:0] resByte = (cmd_q == DSR_CMD_INVALID) ? st0_q :
    (cmd_q == DSR_CMD_SETTRK) ? (prm_q[0][`DSR_BIT_MSB] ? ptn_q[15:8] : ptn_q[7:0]) :
    (resIdx_q == 3'h0) ? st0_q : (resIdx_q == 3'h1) ? st1_q : (resIdx_q == 3'h2) ? st2_q :
    (resIdx_q == 3'h3) ? trk_q : (resIdx_q == 3'h4) ? hd_q : (resIdx_q == 3'h5) ? sec_q : sz_q;
  // control-mark fields skipped under the skip flag are read for crc but never passed on
  wire passByte = (state_q == DSR_DATA) && rdByteValid && (byteCnt_q < xferLen)
    && !(skipFlag && ctrlMark && st2_q[`DSR_S2_CTRLMARK]) && !tcSeen_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dataOut_q <= 8'h00;
      xferValid_q <= 1'b0;
      xferByte_q <= 8'h00;
    end else begin
      dataOut_q <= (dataRead && state_q == DSR_RESULT) ? resByte : 8'h00;
      xferValid_q <= passByte;
      xferByte_q <= passByte ? rdByte : xferByte_q;
    end
  end
  assign dataOut = dataOut_q;
  assign resultReady = (state_q == DSR_RESULT);
  assign irq = irq_q;
  assign seekReq = seekReq_q;
  assign seekTrack = trk_q;
  assign searchReq = (state_q == DSR_SEARCH);
  assign readFieldReq = (state_q == DSR_DATA);
  assign xferValid = xferValid_q;
  assign xferByte = xferByte_q;
  assign head_select = hd_q[0];
  // ***************
  // checks
  // ***************
  property p_abort;
    @(posedge ref_clk) disable iff (!reset_n) abortWr |=> resultReady;
  endproperty
  a_abort: assert property (p_abort) else $error("write while stalled did not abort");
  property p_notfound;
    @(posedge ref_clk) disable iff (!reset_n)
      (state_q == DSR_SEARCH && notFound && !dataWrite) |=> st1_q[`DSR_S1_NODATA] && resultReady;
  endproperty
  a_notfound: assert property (p_notfound) else $error("missing sector not flagged");
  property p_datacrc;
    @(posedge ref_clk) disable iff (!reset_n)
      (state_q == DSR_DATA && dataCrcErr) |=> st1_q[`DSR_S1_CRC] && st2_q[`DSR_S2_CRC];
  endproperty
  a_datacrc: assert property (p_datacrc) else $error("data crc bits not set");
  property p_irq;
    @(posedge ref_clk) disable iff (!reset_n)
      (cmd_q == DSR_CMD_READ && state_q != DSR_IDLE && !resultReady ##1 resultReady) |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt at execution end");
  property p_secinc;
    @(posedge ref_clk) disable iff (!reset_n)
      (state_q == DSR_NEXT && !atEot) |=> sec_q == $past(sec_q) + 8'h01;
  endproperty
  a_secinc: assert property (p_secinc) else $error("sector did not advance");
  property p_invalid;
    @(posedge ref_clk) disable iff (!reset_n)
      (state_q == DSR_IDLE && dataWrite && !isReadOp && !isSetTrk) |=> resultReady
      && st0_q == `DSR_S0_INVALID && resLen_q == 3'h1;
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid opcode not reported");
  property p_xferlen;
    @(posedge ref_clk) disable iff (!reset_n) xferValid |-> $past(byteCnt_q) < $past(xferLen);
  endproperty
  a_xferlen: assert property (p_xferlen) else $error("byte passed beyond length");
  property p_side;
    @(posedge ref_clk) disable iff (!reset_n)
      (state_q == DSR_NEXT && atEot && multiSide && hd_q == 8'h00 && !stopNow && !finalSec_q)
      |=> head_select && sec_q == 8'h01 && state_q == DSR_SEARCH;
  endproperty
  a_side: assert property (p_side) else $error("side change wrong");
endmodule

// ---- hdl/dsr_pkg.sv ----
// types shared by the disk sector read engine
// assumes dsr_consts.svh holds all numeric constants
package dsr_pkg;
  typedef enum logic [3:0] {
    DSR_IDLE = 4'b0000,
    DSR_PARAM = 4'b0001,
    DSR_SEEK = 4'b0010,
    DSR_SETTLE = 4'b0011,
    DSR_SEARCH = 4'b0100,
    DSR_DATA = 4'b0101,
    DSR_NEXT = 4'b0110,
    DSR_RESULT = 4'b0111
  } dsr_state_t;
  typedef enum logic [1:0] {
    DSR_CMD_READ = 2'b00,
    DSR_CMD_SETTRK = 2'b01,
    DSR_CMD_INVALID = 2'b10
  } dsr_cmd_t;
endpackage

// ---- verif/dsr_host_dma.sv ----
// dma-side partner: takes the bytes the engine hands over and ends the transfer on a count
// assumes the bench arms it at each command start and sets the wanted byte count beforehand
`timescale 1ns/1ps
module dsr_host_dma (
  input wire logic ref_clk, // system clock
  input wire logic reset_n, // asynchronous reset, active low
  input wire logic arm, // clears the count for a new command
  input wire logic xferValid, // byte offered by the engine
  input wire logic [7:0] xferByte, // that byte
  input wire logic resultReady, // engine in result phase
  input wire logic [15:0] byteTarget, // bytes wanted, zero means never stop
  output logic transfer_end_input, // transfer end toward the engine
  output logic [15:0] byteCount, // bytes taken this command
  output logic [7:0] lastByte // newest byte taken
);
  // ************
  // counting and transfer end
  // ************
  // end is raised on the last wanted byte and held until results show up,
  // since the engine stops passing bytes once it sees it but only ends the command between sectors
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      byteCount <= 16'h0000;
      lastByte <= 8'h00;
      transfer_end_input <= 1'b0;
    end else begin
      if (arm) begin
        byteCount <= 16'h0000;
      end else if (xferValid) begin
        byteCount <= byteCount + 16'h0001;
        lastByte <= xferByte;
      end
      if (resultReady || arm) begin
        transfer_end_input <= 1'b0;
      end else if (xferValid && byteCount + 16'h0001 == byteTarget) begin
        transfer_end_input <= 1'b1;
      end
    end
  end
endmodule

// ---- verif/dsr_testbench.sv ----
// self-checking bench for the sector read engine: host byte tasks plus a disk-side driver
// assumes dsr_host_dma plays the dma side and raises transfer end on a byte count
`timescale 1ns/1ps
module testbench;
  // ************
  // signals
  // ************
  logic ref_clk, reset_n, dataWrite, dataRead, implied_seek_enable, settleTick, seekDone;
  logic hdrValid, hdrCrcErr, notFound, dataMark, deletedMark, rdByteValid, dataCrcErr, dataCrcOk;
  logic [7:0] dataIn, settleTicks, hdrTrack, hdrHead, hdrSector, hdrSize, rdByte, v;
  logic [7:0] dataOut, seekTrack, xferByte, lastByte, seekTgt;
  logic resultReady, irq, seekReq, searchReq, readFieldReq, xferValid, head_select;
  logic transfer_end_input, arm, seekSeen;
  logic [15:0] byteTarget, byteCount;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int irqCnt = 0;
  int i, z;

  dsr_engine uut (.ref_clk, .reset_n, .dataWrite, .dataRead, .dataIn, .dataOut, .resultReady,
    .irq, .implied_seek_enable, .settleTicks, .settleTick, .transfer_end_input, .seekReq,
    .seekTrack, .seekDone, .searchReq, .hdrValid, .hdrTrack, .hdrHead, .hdrSector, .hdrSize,
    .hdrCrcErr, .notFound, .dataMark, .deletedMark, .rdByteValid, .rdByte, .dataCrcErr,
    .dataCrcOk, .readFieldReq, .xferValid, .xferByte, .head_select);
  dsr_host_dma host (.ref_clk, .reset_n, .arm, .xferValid, .xferByte, .resultReady,
    .byteTarget, .transfer_end_input, .byteCount, .lastByte);

  // clock at 8 ns
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // hang guard, interrupt count and seek capture; seek request is a one-cycle pulse
  always @(posedge ref_clk) begin
    cyc++;
    if (irq === 1'b1) irqCnt++;
    if (seekReq === 1'b1) begin
      seekSeen = 1'b1;
      seekTgt = seekTrack;
    end
    if (cyc == 90000) begin
      n_errors++;
      complete_run;
    end
  end

  // ************
  // tasks
  // ************
  task automatic chk(input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // one-cycle strobes, then a gap so a strobe is never set twice in one step
  task automatic wr(input logic [7:0] b);
    dataWrite <= 1'b1;
    dataIn <= b;
    @(posedge ref_clk);
    dataWrite <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(output logic [7:0] r);
    dataRead <= 1'b1;
    @(posedge ref_clk);
    dataRead <= 1'b0;
    #1 r = dataOut;
    @(posedge ref_clk);
  endtask

  // w: 0 search, 1 field read, 2 results, 3 seek; polled mid-cycle to stay off the edge
  task automatic waitFor(input int w);
    int c;
    logic hit;
    c = 0;
    hit = 1'b0;
    while (!hit && c < 3000) begin
      @(negedge ref_clk);
      c++;
      hit = (w == 0) ? searchReq === 1'b1 : (w == 1) ? readFieldReq === 1'b1 :
        (w == 2) ? resultReady === 1'b1 : seekSeen === 1'b1;
    end
    @(posedge ref_clk);
    chk({15'h0, hit}, 16'h0001);
  endtask

  task automatic rcmd(input logic [7:0] op, p1, t, h, s, sz, e, d);
    logic [7:0] p [8];
    p = '{p1, t, h, s, sz, e, 8'h1b, d};
    irqCnt = 0;
    seekSeen = 1'b0;
    arm <= 1'b1;
    wr(op);
    arm <= 1'b0;
    for (int k = 0; k < 8; k++) wr(p[k]);
  endtask

  // k: 0 good, 1 header crc bad, 2 data crc bad, 3 deleted mark, 4 header only
  task automatic sec(input logic [7:0] t, h, s, sz, input int n, k);
    int j;
    waitFor(0);
    {hdrTrack, hdrHead, hdrSector, hdrSize} <= {t, h, s, sz};
    hdrCrcErr <= (k == 1);
    hdrValid <= 1'b1;
    @(posedge ref_clk);
    hdrValid <= 1'b0;
    if (k == 0 || k == 2 || k == 3) begin
      waitFor(1);
      dataMark <= 1'b1;
      deletedMark <= (k == 3);
      @(posedge ref_clk);
      dataMark <= 1'b0;
      for (j = 0; j < n; j++) begin
        rdByte <= s ^ j[7:0];
        rdByteValid <= 1'b1;
        @(posedge ref_clk);
        rdByteValid <= 1'b0;
        @(posedge ref_clk);
      end
      // margin so a late transfer end clears its synchroniser before the field closes
      repeat (6) @(posedge ref_clk);
      dataCrcErr <= (k == 2);
      dataCrcOk <= (k != 2);
      @(posedge ref_clk);
      {dataCrcErr, dataCrcOk} <= 2'b00;
    end
    @(posedge ref_clk);
  endtask

  task automatic res(input logic [55:0] e, m);
    logic [7:0] r;
    waitFor(2);
    for (int k = 0; k < 7; k++) begin
      rd(r);
      chk(r & m[55-8*k -: 8], e[55-8*k -: 8]);
    end
    chk(irqCnt[15:0], 16'h0001);
  endtask

  // ************
  // tests
  // ************
  initial begin
    {dataWrite, dataRead, settleTick, seekDone, hdrValid, hdrCrcErr, notFound} = '0;
    {dataMark, deletedMark, rdByteValid, dataCrcErr, dataCrcOk, implied_seek_enable} = '0;
    {dataIn, hdrTrack, hdrHead, hdrSector, hdrSize, rdByte} = '0;
    {arm, seekSeen, seekTgt} = '0;
    settleTicks = 8'h03;
    byteTarget = 16'h0000;
    reset_n = 1'b0;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    wr(8'h00);
    waitFor(2);
    rd(v);
    chk(v, 8'h80);
    // both halves written with distinct values, then read back
    for (i = 0; i < 4; i++) begin
      wr(i < 2 ? 8'h61 : 8'h21);
      wr({5'h06, i[0], 2'b00});
      wr(i < 2 ? 8'h5a ^ {8{i[0]}} : 8'h00);
      waitFor(2);
      rd(v);
      chk(v, 8'h5a ^ {8{i[0]}});
    end
    // end-of-read id table; seek flag set while mode-level seek is off
    for (i = 0; i < 4; i++) begin
      byteTarget <= 16'h0004;
      rcmd({i[0], 7'h46}, {1'b1, 4'h0, i[1], 2'b00}, 8'h10, {7'h0, i[1]}, 8'h01, 8'h00,
        (i == 2) ? 8'h03 : 8'h01, 8'h04);
      sec(8'h10, {7'h0, i[1]}, 8'h01, 8'h00, 128, 0);
      chk(byteCount, 16'h0004);
      chk(lastByte, 8'h02);
      res({16'h0, 8'h10 + (i == 0 || i == 3), 7'h0, (i == 1 || i == 2),
        (i == 2) ? 8'h02 : 8'h01, 8'h00}, 56'hc0ffffffffffff);
    end
    byteTarget <= 16'h0008;
    rcmd(8'hc6, 8'h00, 8'h10, 8'h00, 8'h01, 8'h00, 8'h01, 8'h04);
    sec(8'h10, 8'h00, 8'h01, 8'h00, 128, 0);
    @(negedge ref_clk);
    chk(head_select, 1'b1);
    sec(8'h10, 8'h01, 8'h01, 8'h00, 128, 0);
    res({16'h0, 8'h11, 8'h00, 8'h01, 8'h00}, 56'hc0ffffffffffff);
    rcmd(8'h46, 8'h00, 8'h10, 8'h00, 8'h01, 8'h00, 8'h03, 8'h04);
    sec(8'h10, 8'h00, 8'h01, 8'h00, 128, 0);
    sec(8'h10, 8'h00, 8'h02, 8'h00, 128, 0);
    res({16'h0, 8'h10, 8'h00, 8'h03, 8'h00}, 56'hc0ffffffffffff);
    for (z = 1; z < 7; z++) begin
      byteTarget <= 16'(128 << z);
      rcmd(8'h46, 8'h00, 8'h10, 8'h00, 8'h01, z[7:0], 8'h05, 8'hff);
      sec(8'h10, 8'h00, 8'h01, z[7:0], 128 << z, 0);
      chk(byteCount, 16'(128 << z));
      res({16'h0, 8'h10, 8'h00, 8'h02, z[7:0]}, 56'hc0ffffffffffff);
    end
    byteTarget <= 16'h0000;
    rcmd(8'h46, 8'h00, 8'h10, 8'h00, 8'h01, 8'h00, 8'h01, 8'h04);
    sec(8'h10, 8'h00, 8'h01, 8'h00, 128, 0);
    res({8'h40, 8'h80, 40'h0}, {16'hc0ff, 40'h0});
    for (i = 1; i < 3; i++) begin
      rcmd(8'h46, 8'h00, 8'h10, 8'h00, 8'h01, 8'h00, 8'h05, 8'h04);
      sec(8'h10, 8'h00, 8'h01, 8'h00, 128, i);
      res({8'h40, 8'h20, (i == 2) ? 8'h20 : 8'h00, 8'h10, 8'h00, 8'h01, 8'h00},
        56'hc0ffffffffffff);
    end
    for (i = 0; i < 2; i++) begin
      rcmd(8'h46, 8'h03, 8'h10, 8'h00, 8'h01, 8'h00, 8'h05, 8'h04);
      sec(i ? 8'hff : 8'h12, 8'h00, 8'h01, 8'h00, 0, 4);
      waitFor(0);
      notFound <= 1'b1;
      @(posedge ref_clk);
      notFound <= 1'b0;
      res({8'h43, 8'h04, i ? 8'h02 : 8'h10, 32'h0},
        {16'hffff, i ? 8'h02 : 8'hff, 32'h0});
    end
    byteTarget <= 16'h0004;
    rcmd(8'h66, 8'h00, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02, 8'h04);
    sec(8'h10, 8'h00, 8'h01, 8'h00, 128, 3);
    sec(8'h10, 8'h00, 8'h02, 8'h00, 128, 0);
    chk(lastByte, 8'h01);
    res({16'h0040, 8'h11, 8'h00, 8'h01, 8'h00}, 56'hc0ff40ffffffff);
    byteTarget <= 16'h0000;
    // a regular mark is the control mark when deleted data is being read
    for (i = 0; i < 2; i++) begin
      rcmd(i ? 8'h4c : 8'h46, 8'h00, 8'h10, 8'h00, 8'h01, 8'h00, 8'h05, 8'h04);
      sec(8'h10, 8'h00, 8'h01, 8'h00, 128, i ? 0 : 3);
      chk(byteCount, 16'h0004);
      res({16'h0040, 32'h0}, {16'hc0ff, 8'h40, 32'h0});
    end
    // implied seek, settle counted in ticks, then an abort while stalled searching
    implied_seek_enable <= 1'b1;
    rcmd(8'h46, 8'h80, 8'h09, 8'h00, 8'h01, 8'h00, 8'h05, 8'h04);
    waitFor(3);
    chk(seekTgt, 8'h09);
    seekDone <= 1'b1;
    @(posedge ref_clk);
    seekDone <= 1'b0;
    for (i = 0; i < 3; i++) begin
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(searchReq, 1'b0);
      @(posedge ref_clk);
      settleTick <= 1'b1;
      @(posedge ref_clk);
      settleTick <= 1'b0;
    end
    waitFor(0);
    wr(8'h00);
    waitFor(2);
    for (i = 0; i < 7; i++) rd(v);
    @(negedge ref_clk);
    chk(resultReady, 1'b0);
    complete_run;
  end
endmodule
